// ==== src/wdsc_top.sv ====
`timescale 1ns/100ps
`include "wdsc_params.svh"
`default_nettype none

module wdsc_top #(
  parameter int WDOG_CYCLES = `WDSC_WDOG_CYCLES,
  parameter int PC_W       = 13
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Avalon-MM slave.
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Processor core.
  input  wire logic        clear_watchdog_op,
  input  wire logic        sleep_op,
  input  wire logic [PC_W-1:0] core_pc,
  input  wire logic        global_irq_enable,
  input  wire logic [2:0]  irq_flag,
  input  wire logic [2:0]  irq_enable,
  // Pins and fuses.
  input  wire logic        master_clear_n,
  input  wire logic [7:0]  device_config_word,
  // Control and status outputs.
  output logic             device_reset,
  output logic             master_clear_oe,
  output logic             core_stall,
  output logic             osc_driver_off,
  output logic             io_hold,
  output logic             periph_clk_en,
  output logic             wake_pulse,
  output logic             vector_req,
  output logic [PC_W-1:0]  prefetch_addr,
  output logic             timeout_status_n,
  output logic             powerdown_status_n
);

  localparam int BASE_W = $clog2(WDOG_CYCLES);
  localparam int OST_W  = $clog2(`WDSC_OST_CYCLES + 1);

  // Refuse a base period the tick counter cannot count.
  if (WDOG_CYCLES < 2) begin : g_chk
    $error("WDOG_CYCLES must be at least 2");
  end

  // Refuse a program counter too narrow to reach the interrupt vector address.
  if (PC_W < 3) begin : g_chk_pc
    $error("PC_W must be at least 3");
  end

  // Terminal prescaler count: ratio 2**ps when assigned to the watchdog, else 1:1.
  function automatic logic [6:0] wdsc_limit(input logic to_wdog, input logic [2:0] ps);
    logic [6:0] lim;
    lim = 7'h00;
    if (to_wdog) begin
      lim = 7'((8'h01 << ps) - 8'h01);
    end
    return lim;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State and wiring.

  wdsc_pkg::wdsc_state_t state_q;
  wdsc_pkg::wdsc_wake_t  cause_q;
  logic [7:0]        option_q;
  logic [7:0]        config_q;
  logic [BASE_W-1:0] base_q;
  logic [6:0]        pre_q;
  logic [OST_W-1:0]  ost_q;
  logic              wdog_en;
  logic              tick;
  logic              timeout;
  logic              irq_pending;
  logic              sleep_take;
  logic              wdog_clr;
  logic              pin_rst;
  logic              wdog_rst;
  logic              crystal;
  logic              bus_req;
  logic              bus_ack;
  logic              sel_option;
  logic              sel_config;
  logic              sel_status;

  // Fuse bit gates the watchdog off while it reads clear; the word is resampled every clock.
  assign wdog_en     = config_q[`WDSC_CFG_FUSE_EN];
  assign crystal     = config_q[`WDSC_CFG_FOSC_LSB +: 2] != `WDSC_FOSC_RC;
  // Own enable alone decides wake; the global enable plays no part.
  assign irq_pending = |(irq_flag & irq_enable);
  // A sleep with an enabled request already pending is dropped as a no-op.
  assign sleep_take  = sleep_op && state_q == wdsc_pkg::st_run && !irq_pending;
  assign wdog_clr    = sleep_take || (clear_watchdog_op && state_q == wdsc_pkg::st_run);
  assign tick        = base_q == BASE_W'(WDOG_CYCLES - 1);
  // Expiry needs a tick at the terminal prescale count; a clear in that cycle wins.
  assign timeout     = wdog_en && tick && !wdog_clr &&
                       pre_q == wdsc_limit(option_q[`WDSC_OPT_ASSIGN],
                                           option_q[`WDSC_OPT_PS_LSB +: 3]);
  // The pin is taken as a synchronous level, so a pulse shorter than a clock is missed.
  assign pin_rst     = !master_clear_n;
  assign wdog_rst    = timeout && state_q == wdsc_pkg::st_run;
  assign bus_req     = avs_read || avs_write;
  assign bus_ack     = bus_req && !avs_waitrequest;
  assign sel_option  = avs_address == 16'((`WDSC_IDX_OPTION) << 2);
  assign sel_config  = avs_address == 16'((`WDSC_IDX_CONFIG) << 2);
  assign sel_status  = avs_address == 16'((`WDSC_IDX_STATUS) << 2);

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog base tick. It never stops for sleep, standing in for the private RC
  // oscillator, so the timeout still arrives while the core clock is gated.

  always_ff @(posedge core_clk) begin
    if (srst || wdog_clr || pin_rst || !wdog_en || tick) begin
      base_q <= '0;
    end else begin
      base_q <= base_q + BASE_W'(1);
    end
  end

  // Prescaler steps once per tick; cleared together with the counter.
  always_ff @(posedge core_clk) begin
    if (srst || wdog_clr || pin_rst || !wdog_en || timeout) begin
      pre_q <= 7'h00;
    end else if (tick) begin
      pre_q <= pre_q + 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fuse word is captured by a clocked process so reset takes only constants.

  always_ff @(posedge core_clk) begin
    config_q <= device_config_word;
  end

  // Option register; every reset kind restores all ones.
  always_ff @(posedge core_clk) begin
    if (srst || pin_rst || wdog_rst) begin
      option_q <= `WDSC_OPT_RESET;
    end else if (bus_ack && avs_write && sel_option) begin
      option_q <= avs_writedata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power state machine.

  always_ff @(posedge core_clk) begin
    if (srst || pin_rst) begin
      state_q <= wdsc_pkg::st_run;
    end else begin
      unique case (state_q)
        wdsc_pkg::st_run: begin
          if (sleep_take) begin
            state_q <= wdsc_pkg::st_sleep;
          end
        end
        wdsc_pkg::st_sleep: begin
          // Pending requests wake at once, so a late one still finds sleep done.
          if (timeout || irq_pending) begin
            state_q <= crystal ? wdsc_pkg::st_ost : wdsc_pkg::st_run;
          end
        end
        wdsc_pkg::st_ost: begin
          if (ost_q == OST_W'(`WDSC_OST_CYCLES - 1)) begin
            state_q <= wdsc_pkg::st_run;
          end
        end
        default: state_q <= wdsc_pkg::st_run;
      endcase
    end
  end

  // Oscillator start-up counter, only live in the start-up wait.
  always_ff @(posedge core_clk) begin
    if (srst || state_q != wdsc_pkg::st_ost) begin
      ost_q <= '0;
    end else begin
      ost_q <= ost_q + OST_W'(1);
    end
  end

  // Wake cause, held until the core resumes.
  always_ff @(posedge core_clk) begin
    if (srst || pin_rst || state_q == wdsc_pkg::st_run) begin
      cause_q <= wdsc_pkg::wake_none;
    end else if (state_q == wdsc_pkg::st_sleep && timeout) begin
      cause_q <= wdsc_pkg::wake_wdog;
    end else if (state_q == wdsc_pkg::st_sleep && irq_pending) begin
      cause_q <= wdsc_pkg::wake_irq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status bits. Master clear leaves both untouched so software can tell it apart.

  always_ff @(posedge core_clk) begin
    if (srst) begin
      timeout_status_n <= 1'b1;
    end else if (timeout) begin
      timeout_status_n <= 1'b0;
    end else if (sleep_take) begin
      timeout_status_n <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      powerdown_status_n <= 1'b1;
    end else if (sleep_take) begin
      powerdown_status_n <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Core-facing outputs.

  // Reset request is internal only; the pin driver is never enabled.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      device_reset    <= 1'b1;
      master_clear_oe <= 1'b0;
    end else begin
      device_reset    <= wdog_rst || pin_rst;
      master_clear_oe <= 1'b0;
    end
  end

  // Stall and hold follow the next state so they rise with the sleep state.
  always_ff @(posedge core_clk) begin
    if (srst || pin_rst) begin
      core_stall     <= 1'b0;
      osc_driver_off <= 1'b0;
      io_hold        <= 1'b0;
      periph_clk_en  <= 1'b1;
    end else if (sleep_take) begin
      core_stall     <= 1'b1;
      osc_driver_off <= 1'b1;
      io_hold        <= 1'b1;
      periph_clk_en  <= 1'b0;
    end else if (state_q == wdsc_pkg::st_sleep && (timeout || irq_pending)) begin
      core_stall     <= crystal;
      osc_driver_off <= 1'b0;
      io_hold        <= crystal;
      periph_clk_en  <= !crystal;
    end else if (state_q == wdsc_pkg::st_ost &&
                 ost_q == OST_W'(`WDSC_OST_CYCLES - 1)) begin
      core_stall     <= 1'b0;
      io_hold        <= 1'b0;
      periph_clk_en  <= 1'b1;
    end
  end

  // Resume pulse; the core runs the prefetched instruction, then vectors if asked.
  always_ff @(posedge core_clk) begin
    if (srst || pin_rst) begin
      wake_pulse <= 1'b0;
      vector_req <= 1'b0;
    end else if (state_q == wdsc_pkg::st_sleep && !crystal && (timeout || irq_pending)) begin
      wake_pulse <= 1'b1;
      vector_req <= !timeout && global_irq_enable;
    end else if (state_q == wdsc_pkg::st_ost &&
                 ost_q == OST_W'(`WDSC_OST_CYCLES - 1)) begin
      wake_pulse <= 1'b1;
      vector_req <= cause_q == wdsc_pkg::wake_irq && global_irq_enable;
    end else begin
      wake_pulse <= 1'b0;
      vector_req <= 1'b0;
    end
  end

  // Address of the instruction fetched while sleep executes.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prefetch_addr <= '0;
    end else if (sleep_take) begin
      prefetch_addr <= core_pc + PC_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the answer. Unmapped reads return zero and
  // unmapped writes are dropped.

  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
    end
  end

  // Read data is captured on the request edge, so it already stands when waitrequest drops.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= 32'h0000_0000;
      if (sel_option) begin
        avs_readdata[7:0] <= option_q;
      end else if (sel_config) begin
        avs_readdata[7:0] <= config_q;
      end else if (sel_status) begin
        avs_readdata[`WDSC_STAT_TMOUT] <= timeout_status_n;
        avs_readdata[`WDSC_STAT_PWRDN] <= powerdown_status_n;
      end
    end
  end

endmodule // wdsc_top

`default_nettype wire

// ==== pkg/wdsc_params.svh ====
`ifndef WDSC_PARAMS_SVH
`define WDSC_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define WDSC_IDX_OPTION   16'h0081
`define WDSC_IDX_CONFIG   16'h2007
`define WDSC_IDX_STATUS   16'h0003

// Option register fields and reset value.
`define WDSC_OPT_RESET    8'hFF
`define WDSC_OPT_ASSIGN   3
`define WDSC_OPT_PS_LSB   0

// Config word fields.
`define WDSC_CFG_FUSE_EN  2
`define WDSC_CFG_FOSC_LSB 0
`define WDSC_FOSC_RC      2'h3

// Status field positions.
`define WDSC_STAT_TMOUT   4
`define WDSC_STAT_PWRDN   3

// Timing: watchdog base period in microseconds, core clock in MHz.
`define WDSC_WDOG_PERIOD_US 18000
`define WDSC_CORE_CLK_MHZ   125
`define WDSC_WDOG_CYCLES    (`WDSC_WDOG_PERIOD_US * `WDSC_CORE_CLK_MHZ)
// Oscillator start-up wait in oscillator periods; one period is one core clock.
`define WDSC_OST_TOSC      1024
`define WDSC_OST_CYCLES    (`WDSC_OST_TOSC * 1)

`endif

// ==== pkg/wdsc_pkg.sv ====
`default_nettype none
package wdsc_pkg;

  // Power state of the core.
  typedef enum logic [1:0] {
    st_run   = 2'b00,
    st_sleep = 2'b01,
    st_ost   = 2'b10
  } wdsc_state_t;

  // Cause of the most recent wake-up.
  typedef enum logic [1:0] {
    wake_none = 2'b00,
    wake_wdog = 2'b01,
    wake_irq  = 2'b10
  } wdsc_wake_t;

endpackage
`default_nettype wire

// ==== sim/wdsc_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module wdsc_monitor #(
  parameter int PC_W = 13
) (
  // Clock and reset.
  input wire logic            core_clk,
  input wire logic            srst,
  // Core and pins.
  input wire logic            sleep_op,
  input wire logic [PC_W-1:0] core_pc,
  input wire logic            global_irq_enable,
  input wire logic [2:0]      irq_flag,
  input wire logic [2:0]      irq_enable,
  input wire logic            master_clear_n,
  input wire logic [7:0]      device_config_word,
  // Outputs.
  input wire logic            device_reset,
  input wire logic            master_clear_oe,
  input wire logic            core_stall,
  input wire logic            osc_driver_off,
  input wire logic            io_hold,
  input wire logic            periph_clk_en,
  input wire logic            wake_pulse,
  input wire logic            vector_req,
  input wire logic [PC_W-1:0] prefetch_addr,
  input wire logic            timeout_status_n,
  input wire logic            powerdown_status_n
);
  logic        pend;
  logic [10:0] ost_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // An enabled flag wakes or blocks sleep whatever the global enable says.
  assign pend = |(irq_flag & irq_enable);
  // Counts cycles spent stalled with the oscillator back on, to time the start-up wait.
  always_ff @(posedge core_clk) begin
    ost_q <= (srst || !core_stall || osc_driver_off) ? 11'h000 : ost_q + 11'h001;
  end
  ////////////////////////////////////////
  pin_quiet_a:
    assert property (!master_clear_oe) else $error("reset pin driven");
  sleep_take_a:
    assert property (sleep_op && !core_stall && !pend && master_clear_n |=> core_stall
      && osc_driver_off && !powerdown_status_n && timeout_status_n
      && prefetch_addr == $past(core_pc) + 1'b1) else $error("sleep entry wrong");
  sleep_nop_a:
    assert property (sleep_op && !core_stall && pend && master_clear_n |=> !core_stall
      && powerdown_status_n == $past(powerdown_status_n)) else $error("pending sleep not a no-op");
  hold_mirror_a:
    assert property (io_hold == core_stall && periph_clk_en != core_stall)
      else $error("hold or peripheral clock wrong");
  irq_wake_a:
    assert property (osc_driver_off && pend && master_clear_n && device_config_word[1:0] == 2'h3
      |=> wake_pulse && !core_stall && vector_req == $past(global_irq_enable))
      else $error("interrupt wake wrong");
  ost_wait_a:
    assert property ($fell(core_stall) && !device_reset && device_config_word[1:0] != 2'h3
      |-> ost_q >= 11'd1022 && ost_q <= 11'd1025) else $error("start-up wait length wrong");
  wake_quiet_a:
    assert property (wake_pulse |-> !device_reset && !osc_driver_off) else $error("wake reset");
  wdog_run_a:
    assert property ($fell(timeout_status_n) && !$past(osc_driver_off) |-> ##[0:1] device_reset)
      else $error("running timeout without reset");
  fuse_off_a:
    assert property (!device_config_word[2] && !$past(device_config_word[2])
      && !$past(device_config_word[2], 2) |-> !$fell(timeout_status_n)) else $error("fuse ignored");
endmodule // wdsc_monitor
bind wdsc_top wdsc_monitor #(.PC_W(PC_W)) mon_u (.core_clk(core_clk), .srst(srst),
  .sleep_op(sleep_op), .core_pc(core_pc), .global_irq_enable(global_irq_enable),
  .irq_flag(irq_flag), .irq_enable(irq_enable), .master_clear_n(master_clear_n),
  .device_config_word(device_config_word), .device_reset(device_reset),
  .master_clear_oe(master_clear_oe), .core_stall(core_stall), .osc_driver_off(osc_driver_off),
  .io_hold(io_hold), .periph_clk_en(periph_clk_en), .wake_pulse(wake_pulse),
  .vector_req(vector_req), .prefetch_addr(prefetch_addr), .timeout_status_n(timeout_status_n),
  .powerdown_status_n(powerdown_status_n));
`default_nettype wire

// ==== sim/wdsc_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module wdsc_core_model (
  // Clock and stall.
  input wire logic        core_clk,
  input wire logic        core_stall,
  // Bench requests.
  input wire logic        want_sleep,
  input wire logic        want_clear,
  input wire logic [12:0] pc_in,
  // Instruction pulses.
  output logic            sleep_op,
  output logic            clear_watchdog_op,
  output logic [12:0]     core_pc
);
  // A stalled core fetches nothing, so it cannot issue either instruction.
  always_ff @(posedge core_clk) begin
    sleep_op          <= want_sleep && !core_stall;
    clear_watchdog_op <= want_clear && !core_stall;
  end
  // Outside a sleep the address is scrambled so a stale capture shows up.
  always_ff @(posedge core_clk) begin
    core_pc <= want_sleep ? pc_in : ~pc_in;
  end
endmodule // wdsc_core_model
`default_nettype wire

// ==== sim/watchdog_sleep_wake_control_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module watchdog_sleep_wake_control_bench;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd_q[$];
  logic [15:0] avs_address = 16'h0000;
  logic [12:0] core_pc, prefetch_addr, pc_in = 13'h0000;
  logic [7:0]  device_config_word = 8'h07, v;
  logic [7:0]  opt_t[3] = '{8'h00, 8'h0a, 8'h0f};
  logic [2:0]  irq_flag = 3'h0, irq_enable = 3'h0;
  logic        core_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, g;
  logic        global_irq_enable = 1'b0, master_clear_n = 1'b1, want_sleep = 1'b0;
  logic        want_clear = 1'b0, sleep_op, clear_watchdog_op, avs_waitrequest, device_reset;
  logic        master_clear_oe, core_stall, osc_driver_off, io_hold, periph_clk_en;
  logic        wake_pulse, vector_req, timeout_status_n, powerdown_status_n;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0, n, e;
  // Free-running 125 MHz clock.
  always #4 core_clk = ~core_clk;
  wdsc_top #(.WDOG_CYCLES(8)) dut_u (.core_clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .clear_watchdog_op, .sleep_op, .core_pc,
    .global_irq_enable, .irq_flag, .irq_enable, .master_clear_n, .device_config_word,
    .device_reset, .master_clear_oe, .core_stall, .osc_driver_off, .io_hold, .periph_clk_en,
    .wake_pulse, .vector_req, .prefetch_addr, .timeout_status_n, .powerdown_status_n);
  wdsc_core_model core_u (.core_clk, .core_stall, .want_sleep, .want_clear, .pc_in,
    .sleep_op, .clear_watchdog_op, .core_pc);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Holds the request until waitrequest is sampled low, then idles one cycle.
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    rd_q.push_back(x);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic op(input logic s);
    if (s) want_sleep <= 1'b1;
    else want_clear <= 1'b1;
    @(posedge core_clk);
    want_sleep <= 1'b0;
    want_clear <= 1'b0;
    @(posedge core_clk);
  endtask
  // Counts edges until a reset or a wake pulse is sampled.
  task automatic wait_for(input logic r, output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while ((r ? device_reset : wake_pulse) !== 1'b1 && k < 3000);
  endtask
  ////////////////////////////////////////
  // Read data is judged at the acknowledging edge against the oldest note.
  always @(posedge core_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && rd_q.size() > 0)
      chk(avs_readdata, rd_q.pop_front());
  end
  // A cycle ceiling cuts a hang short well above the expected run length.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  // Main sequence; the fuse is dropped while retuning the prescaler so no stale count fires.
  initial begin
    n = $urandom(32'h8739);
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    v = 8'($urandom) | 8'h0f;
    rd(16'h0204, 32'h0000_00ff);
    rd(16'h000c, 32'h0000_0018);
    bus(1'b1, 16'h801c, {24'h00_0000, ~v});
    rd(16'h801c, 32'h0000_0007);
    bus(1'b1, 16'h0204, {24'h00_0000, v});
    rd(16'h0204, {24'h00_0000, v});
    rd(16'h0100, 32'h0000_0000);
    foreach (opt_t[i]) begin
      device_config_word <= 8'h03;
      bus(1'b1, 16'h0204, {24'h00_0000, opt_t[i]});
      device_config_word <= 8'h07;
      repeat (6) op(1'b0);
      wait_for(1'b1, n);
      e = opt_t[i][3] ? 8 << opt_t[i][2:0] : 8;
      chk(32'(n >= e - 2 && n <= e + 2), 32'h0000_0001);
      rd(16'h000c, 32'h0000_0008);
    end
    irq_flag <= 3'h2;
    irq_enable <= 3'h2;
    op(1'b1);
    rd(16'h000c, 32'h0000_0008);
    g = 1'($urandom);
    pc_in <= 13'($urandom);
    irq_flag <= 3'h0;
    irq_enable <= 3'h1 << ($urandom % 3);
    global_irq_enable <= g;
    op(1'b1);
    @(posedge core_clk);
    chk(32'(prefetch_addr), 32'(13'(pc_in + 13'h0001)));
    rd(16'h000c, 32'h0000_0010);
    irq_flag <= ~irq_enable;
    repeat (4) @(posedge core_clk);
    chk(32'(core_stall), 32'h0000_0001);
    irq_flag <= irq_enable;
    wait_for(1'b0, n);
    chk(32'(vector_req), 32'(g));
    chk(32'(n <= 2), 32'h0000_0001);
    irq_flag <= 3'h0;
    device_config_word <= 8'h03;
    bus(1'b1, 16'h0204, 32'h0000_0008);
    device_config_word <= 8'h07;
    op(1'b1);
    wait_for(1'b0, n);
    device_config_word <= 8'h00;
    chk(32'(n <= 14), 32'h0000_0001);
    rd(16'h000c, 32'h0000_0000);
    op(1'b1);
    irq_flag <= irq_enable;
    wait_for(1'b0, n);
    chk(32'(n >= 1022 && n <= 1028), 32'h0000_0001);
    irq_flag <= 3'h0;
    device_config_word <= 8'h07;
    op(1'b1);
    master_clear_n <= 1'b0;
    wait_for(1'b1, n);
    master_clear_n <= 1'b1;
    chk(32'(n <= 3), 32'h0000_0001);
    rd(16'h000c, 32'h0000_0010);
    rd(16'h0204, 32'h0000_00ff);
    report_and_stop();
  end
endmodule // watchdog_sleep_wake_control_bench
`default_nettype wire
